// file: rtl/fmscs_top.sv
// Purpose: Scan control and receive status register bank of an FM receiver
// Assumes: Register port and measurement inputs are on the system clock
// Notes: Read data is registered, one cycle behind the address
//
// Notes on behaviour
// - Device clears scan request when scan ends
// - Source bit and scan request accepted together
// - Source zero: scanned channel; one: host index
// - Bit 7 selects sine or digital injection
// - Image bit: host value, or scan choice
// - Valid channel: dBuV above threshold minus ten
// - Signal-to-noise shown as read-only byte
// - Strength shown as raw RSSI minus 43
// - Three-bit top state code reported
// - Hit keeps channel, miss sets flag
// - AGC settled, AGC error, mono bits reported
// - Scan needs scan request plus receive request
// - Scan stops at first valid channel
// - Frequency is 60 MHz plus index times 50 kHz
`timescale 1ns/1ps
`default_nettype none
module fmscs_top #(
  parameter int CAL = fmscs_pkg::CAL_CYCLES,
  parameter int PLLCAL = fmscs_pkg::PLL_CYCLES,
  parameter int DWELL = fmscs_pkg::DWELL_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [9:0] tuned_station_index_i,
  input wire fmscs_pkg::fmscs_scan_cfg_t scan_cfg_i,
  input wire fmscs_pkg::fmscs_meas_t meas_i,
  input wire logic image_pref_i,
  output logic [9:0] tuned_station_index_o,
  output logic [16:0] tuned_freq_khz_o,
  output logic reference_injection_type_o,
  output logic image_side_o,
  output logic [2:0] fsm_code_o
);
  typedef enum logic [2:0] {
    F_STANDBY, F_RESET, F_CAL, F_IDLE, F_PLLCAL, F_RECEIVE, F_RXSCAN
  } fmscs_fsm_t;

  fmscs_fsm_t fsm_r, fsm_nxt;
  logic [7:0] sys_r, sys_nxt;
  logic [7:0] thr_r, thr_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [9:0] chan_r, chan_nxt;
  logic [16:0] freq_r, freq_nxt;
  logic [2:0] code;
  logic [7:0] rssi_dbuv;
  logic [7:0] thr_view;
  logic [7:0] state_view;
  logic scan_start, scan_abort, scan_busy, scan_done, scan_fail, scan_img;
  logic [9:0] scan_chan;
  logic wr_sys, wr_thr, soft_rst, restart;

  assign wr_sys = reg_wr_i && (reg_addr_i == fmscs_pkg::ADDR_SYSTEM);
  assign wr_thr = reg_wr_i && (reg_addr_i == fmscs_pkg::ADDR_THRESHOLD);
  assign soft_rst = wr_sys && reg_wdata_i[fmscs_pkg::SYS_SWRST_BIT];
  assign restart = soft_rst || (wr_sys && reg_wdata_i[fmscs_pkg::SYS_RECAL_BIT]); // Both restart

  // Scan starts only from pll calibration with both requests set
  assign scan_start = (fsm_r == F_PLLCAL) && (wait_r == 8'h00)
    && sys_r[fmscs_pkg::SYS_SCANREQ_BIT] && sys_r[fmscs_pkg::SYS_RXREQ_BIT];
  assign scan_abort = (fsm_r == F_RXSCAN) && (!sys_r[fmscs_pkg::SYS_RXREQ_BIT] || restart);

  // Host-visible registers; self-reset bits are never stored
  always_comb
  begin
    sys_nxt = sys_r;
    thr_nxt = thr_r;
    if (wr_sys)
    begin
      // Both source and scan request land in one write
      sys_nxt = reg_wdata_i;
      sys_nxt[fmscs_pkg::SYS_SWRST_BIT] = 1'b0;
      sys_nxt[fmscs_pkg::SYS_RECAL_BIT] = 1'b0;
    end
    else if (scan_done || scan_abort)
    begin
      // A host write in the same cycle wins over the self-clear
      sys_nxt[fmscs_pkg::SYS_SCANREQ_BIT] = 1'b0;
    end
    if (wr_thr)
    begin
      thr_nxt = reg_wdata_i;
    end
    if (soft_rst)
    begin
      sys_nxt = fmscs_pkg::SYSTEM_RESET;
      thr_nxt = fmscs_pkg::THRESHOLD_RESET;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sys_r <= fmscs_pkg::SYSTEM_RESET;
      thr_r <= fmscs_pkg::THRESHOLD_RESET;
    end
    else
    begin
      sys_r <= sys_nxt;
      thr_r <= thr_nxt;
    end
  end

  // Top state machine; standby wins unless receive is requested or a restart is written
  always_comb
  begin
    fsm_nxt = fsm_r;
    wait_nxt = (wait_r != 8'h00) ? wait_r - 8'h01 : 8'h00;
    case (fsm_r)
      F_STANDBY:
        if (!sys_r[fmscs_pkg::SYS_STNBY_BIT])
          fsm_nxt = F_IDLE;
      F_RESET:
      begin
        fsm_nxt = F_CAL;
        wait_nxt = 8'(CAL - 1);
      end
      F_CAL:
        if (wait_r == 8'h00)
          fsm_nxt = F_IDLE;
      F_IDLE:
        if (sys_r[fmscs_pkg::SYS_RXREQ_BIT])
        begin
          fsm_nxt = F_PLLCAL;
          wait_nxt = 8'(PLLCAL - 1);
        end
      F_PLLCAL:
        if (wait_r == 8'h00)
          fsm_nxt = scan_start ? F_RXSCAN : F_RECEIVE;
      F_RECEIVE:
        if (!sys_r[fmscs_pkg::SYS_RXREQ_BIT])
          fsm_nxt = F_IDLE;
        else if (sys_r[fmscs_pkg::SYS_SCANREQ_BIT])
        begin
          fsm_nxt = F_PLLCAL;
          wait_nxt = 8'(PLLCAL - 1);
        end
      F_RXSCAN:
        if (scan_abort)
          fsm_nxt = F_IDLE;
        else if (scan_done)
          fsm_nxt = F_RECEIVE;
      default:
        fsm_nxt = F_RESET;
    endcase
    if (sys_r[fmscs_pkg::SYS_STNBY_BIT] && !sys_r[fmscs_pkg::SYS_RXREQ_BIT])
      fsm_nxt = F_STANDBY;
    // Restart also aborts a running scan, so engine and state stay in step
    if (restart)
      fsm_nxt = F_RESET;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      fsm_r <= F_RESET;
      wait_r <= 8'h00;
    end
    else
    begin
      fsm_r <= fsm_nxt;
      wait_r <= wait_nxt;
    end
  end

  // State code as reported to the host
  always_comb
  begin
    case (fsm_r)
      F_STANDBY: code = fmscs_pkg::CODE_STANDBY;
      F_RESET: code = fmscs_pkg::CODE_RESET;
      F_CAL: code = fmscs_pkg::CODE_CAL;
      F_IDLE: code = fmscs_pkg::CODE_IDLE;
      F_PLLCAL: code = fmscs_pkg::CODE_PLLCAL;
      F_RECEIVE: code = fmscs_pkg::CODE_RECEIVE;
      F_RXSCAN: code = fmscs_pkg::CODE_RXSCAN;
      default: code = fmscs_pkg::CODE_RESET;
    endcase
  end

  fmscs_scan #(
    .DWELL(DWELL)
  ) u_scan (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(scan_start),
    .abort_i(scan_abort),
    .cfg_i(scan_cfg_i),
    .rssi_raw_i(meas_i.rssi_raw),
    .threshold_i(thr_r[fmscs_pkg::THR_LEVEL_W-1:0]),
    .image_pref_i(image_pref_i),
    .busy_o(scan_busy),
    .done_o(scan_done),
    .fail_o(scan_fail),
    .chan_o(scan_chan),
    .image_o(scan_img)
  );

  // Read views; plain muxes so reads cannot disturb any state
  assign rssi_dbuv = meas_i.rssi_raw - fmscs_pkg::RSSI_OFFSET[7:0];
  always_comb
  begin
    thr_view = thr_r;
    if (!sys_r[fmscs_pkg::SYS_SRC_BIT])
    begin
      thr_view[fmscs_pkg::THR_IMG_BIT] = scan_img;
    end
    state_view = 8'h00;
    state_view[fmscs_pkg::ST_FSM_LSB +: 3] = code;
    state_view[fmscs_pkg::ST_FAIL_BIT] = scan_fail;
    state_view[fmscs_pkg::ST_AGCSET_BIT] = meas_i.agc_settled;
    state_view[fmscs_pkg::ST_AGCERR_BIT] = meas_i.agc_error;
    state_view[fmscs_pkg::ST_MONO_BIT] = meas_i.mono_indicator;
    case (reg_addr_i)
      fmscs_pkg::ADDR_SYSTEM: rdata_nxt = sys_r;
      fmscs_pkg::ADDR_THRESHOLD: rdata_nxt = thr_view;
      fmscs_pkg::ADDR_SNR: rdata_nxt = meas_i.signal_to_noise_level;
      fmscs_pkg::ADDR_RSSI: rdata_nxt = rssi_dbuv;
      fmscs_pkg::ADDR_STATE: rdata_nxt = state_view;
      default: rdata_nxt = 8'h00;
    endcase
    // Channel source and frequency in 50 kHz steps above 60 MHz
    chan_nxt = sys_r[fmscs_pkg::SYS_SRC_BIT] ? tuned_station_index_i : scan_chan;
    freq_nxt = fmscs_pkg::BASE_FREQ_KHZ + 17'(chan_r) * 17'(fmscs_pkg::STEP_KHZ);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rdata_r <= 8'h00;
      chan_r <= 10'h000;
      freq_r <= fmscs_pkg::BASE_FREQ_KHZ;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      chan_r <= chan_nxt;
      freq_r <= freq_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign tuned_station_index_o = chan_r;
  assign tuned_freq_khz_o = freq_r;
  assign reference_injection_type_o = thr_r[fmscs_pkg::THR_INJ_BIT];
  assign image_side_o = thr_view[fmscs_pkg::THR_IMG_BIT];
  assign fsm_code_o = code;

  req_self_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (scan_done && !wr_sys) |=> !sys_r[fmscs_pkg::SYS_SCANREQ_BIT])
    else $error("scan request not cleared after scan end");
  scan_needs_rx_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (fsm_r != F_RXSCAN) ##1 (fsm_r == F_RXSCAN) |-> $past(sys_r[fmscs_pkg::SYS_RXREQ_BIT]))
    else $error("scan entered without receive request");
  source_pick_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ##1 $stable(sys_r[fmscs_pkg::SYS_SRC_BIT]) |-> (chan_r == ($past(sys_r[fmscs_pkg::SYS_SRC_BIT])
      ? $past(tuned_station_index_i) : $past(scan_chan))))
    else $error("tuned index from wrong source");
  freq_map_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ##2 1'b1 |-> (freq_r == 17'(60000 + 50 * $past(chan_r))))
    else $error("frequency does not follow index");
  rssi_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (reg_addr_i == fmscs_pkg::ADDR_RSSI) |=> (reg_rdata_o == 8'($past(meas_i.rssi_raw) - 8'd43)))
    else $error("strength read not raw minus 43");
  code_rx_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (scan_busy |-> fsm_code_o == 3'h7) and ((fsm_r == F_RECEIVE) |-> fsm_code_o == 3'h5))
    else $error("state code mismatch");
  status_bits_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (reg_addr_i == fmscs_pkg::ADDR_STATE) |=> (reg_rdata_o[2:0] == $past({meas_i.agc_settled,
      meas_i.agc_error, meas_i.mono_indicator})))
    else $error("status bits wrong");
  image_view_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    image_side_o == (sys_r[0] ? thr_r[6] : scan_img))
    else $error("image side view wrong");
  inject_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_thr |=> (reference_injection_type_o == $past(reg_wdata_i[7])))
    else $error("injection bit not taken");
endmodule : fmscs_top
`default_nettype wire

// file: rtl/fmscs_pkg.sv
// Purpose: Shared constants and carriers for the FM scan control/status bank
// Assumes: 8-bit register port, byte offsets as printed, 20 MHz system clock
// Notes: Cycle counts for calibration and dwell are plain defaults
package fmscs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SYSTEM = 8'h00;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h01;
  localparam logic [7:0] ADDR_SNR = 8'h02;
  localparam logic [7:0] ADDR_RSSI = 8'h03;
  localparam logic [7:0] ADDR_STATE = 8'h04;

  // System register bit positions
  localparam int SYS_SWRST_BIT = 7;
  localparam int SYS_RECAL_BIT = 6;
  localparam int SYS_STNBY_BIT = 5;
  localparam int SYS_RXREQ_BIT = 4;
  localparam int SYS_SCANREQ_BIT = 1;
  localparam int SYS_SRC_BIT = 0;

  // Threshold/config register bit positions
  localparam int THR_INJ_BIT = 7;
  localparam int THR_IMG_BIT = 6;
  localparam int THR_LEVEL_W = 6;

  // State/flags register bit positions
  localparam int ST_FSM_LSB = 4;
  localparam int ST_FAIL_BIT = 3;
  localparam int ST_AGCSET_BIT = 2;
  localparam int ST_AGCERR_BIT = 1;
  localparam int ST_MONO_BIT = 0;

  // Values after reset
  localparam logic [7:0] SYSTEM_RESET = 8'h01;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;

  // Arithmetic offsets
  localparam logic [9:0] RSSI_OFFSET = 10'h02B;
  localparam logic [9:0] THR_OFFSET = 10'h00A;
  localparam logic [16:0] BASE_FREQ_KHZ = 17'h0EA60;
  localparam logic [6:0] STEP_KHZ = 7'h32;

  // Reported state codes
  localparam logic [2:0] CODE_STANDBY = 3'h0;
  localparam logic [2:0] CODE_RESET = 3'h1;
  localparam logic [2:0] CODE_CAL = 3'h2;
  localparam logic [2:0] CODE_IDLE = 3'h3;
  localparam logic [2:0] CODE_PLLCAL = 3'h4;
  localparam logic [2:0] CODE_RECEIVE = 3'h5;
  localparam logic [2:0] CODE_RXSCAN = 3'h7;

  // Cycle counts
  localparam int CAL_CYCLES = 64;
  localparam int PLL_CYCLES = 16;
  localparam int DWELL_CYCLES = 8;

  typedef struct packed {
    logic [7:0] signal_to_noise_level;
    logic [7:0] rssi_raw;
    logic agc_settled;
    logic agc_error;
    logic mono_indicator;
  } fmscs_meas_t;

  typedef struct packed {
    logic [9:0] start_index;
    logic [9:0] stop_index;
    logic [1:0] fstep;
  } fmscs_scan_cfg_t;

endpackage : fmscs_pkg

// file: rtl/fmscs_scan.sv
// Purpose: Channel scan engine, stops at the first channel above threshold minus ten
// Assumes: Measurements settle within the dwell count after a retune
// Notes: Abort drops back to idle and masks done; an abort in the judge cycle still updates the result
`timescale 1ns/1ps
`default_nettype none
module fmscs_scan #(
  parameter int DWELL = fmscs_pkg::DWELL_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire fmscs_pkg::fmscs_scan_cfg_t cfg_i,
  input wire logic [7:0] rssi_raw_i,
  input wire logic [5:0] threshold_i,
  input wire logic image_pref_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic [9:0] chan_o,
  output logic image_o
);
  typedef enum logic [1:0] {S_IDLE, S_DWELL, S_JUDGE} fmscs_scan_state_t;

  fmscs_scan_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [9:0] chan_r, chan_nxt;
  logic fail_r, fail_nxt;
  logic img_r, img_nxt;
  logic done_r, done_nxt;
  logic signed [9:0] dbuv_s;
  logic signed [9:0] floor_s;
  logic valid;
  logic [10:0] step;
  logic [10:0] sum;

  // Strength in dBuV against threshold less ten, signed to cover low levels
  assign dbuv_s = $signed({2'b00, rssi_raw_i}) - $signed(fmscs_pkg::RSSI_OFFSET);
  assign floor_s = $signed({4'b0000, threshold_i}) - $signed(fmscs_pkg::THR_OFFSET);
  assign valid = dbuv_s > floor_s;
  // Reserved step code falls back to 100 kHz
  assign step = (cfg_i.fstep == 2'h0) ? 11'h001 : (cfg_i.fstep == 2'h2) ? 11'h004 : 11'h002;
  assign sum = {1'b0, chan_r} + step;

  // Next-state logic of the scan walk
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    fail_nxt = fail_r;
    img_nxt = img_r;
    done_nxt = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (start_i)
        begin
          chan_nxt = cfg_i.start_index;
          cnt_nxt = 8'h00;
          state_nxt = S_DWELL;
        end
      end
      S_DWELL:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'(DWELL - 1))
        begin
          state_nxt = S_JUDGE;
        end
      end
      S_JUDGE:
      begin
        cnt_nxt = 8'h00;
        if (valid)
        begin
          // First hit wins, no search for the best
          fail_nxt = 1'b0;
          img_nxt = image_pref_i;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
        else if (chan_r >= cfg_i.stop_index || sum > {1'b0, cfg_i.stop_index})
        begin
          chan_nxt = cfg_i.stop_index;
          fail_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
        else
        begin
          chan_nxt = sum[9:0];
          state_nxt = S_DWELL;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
    if (abort_i)
    begin
      state_nxt = S_IDLE;
      done_nxt = 1'b0;
    end
  end

  // Scan registers
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= S_IDLE;
      cnt_r <= 8'h00;
      chan_r <= 10'h000;
      fail_r <= 1'b0;
      img_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      fail_r <= fail_nxt;
      img_r <= img_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_o = (state_r != S_IDLE);
  assign done_o = done_r;
  assign fail_o = fail_r;
  assign chan_o = chan_r;
  assign image_o = img_r;

  hit_stops_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_r == S_JUDGE && valid && !abort_i) |=> (state_r == S_IDLE && done_r && !fail_r))
    else $error("scan did not stop on first valid channel");
  miss_at_end_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (done_r && fail_r) |-> (chan_r == cfg_i.stop_index))
    else $error("failed scan not parked at stop index");
endmodule : fmscs_scan
`default_nettype wire

// file: verif/fmscs_rf_model.sv
// Purpose: Far-side stand-in that answers the tuned index with measurements
// Assumes: Measurements follow the tuned index within a cycle
// Notes: Off-station level sits exactly on a threshold of 20, never above it
`timescale 1ns/1ps
`default_nettype none
module fmscs_rf_model (
  input wire logic clk_sys_i,
  input wire logic [9:0] index_i,
  input wire logic [9:0] station_a_i,
  input wire logic [9:0] station_b_i,
  input wire logic [7:0] snr_i,
  input wire logic [2:0] flags_i,
  output var fmscs_pkg::fmscs_meas_t meas_o
);
  // Weak station just passes, strong one far above, floor is a near miss
  localparam logic [7:0] LVL_A = 8'h36;
  localparam logic [7:0] LVL_B = 8'h5A;
  localparam logic [7:0] LVL_FLOOR = 8'h35;

  // Updated on the falling edge so the device samples settled values
  initial
  begin
    forever
    begin
      meas_o.signal_to_noise_level = snr_i;
      meas_o.agc_settled = flags_i[2];
      meas_o.agc_error = flags_i[1];
      meas_o.mono_indicator = flags_i[0];
      if (index_i === station_a_i)
        meas_o.rssi_raw = LVL_A;
      else if (index_i === station_b_i)
        meas_o.rssi_raw = LVL_B;
      else
        meas_o.rssi_raw = LVL_FLOOR;
      @(negedge clk_sys_i);
    end
  end
endmodule : fmscs_rf_model
`default_nettype wire

// file: verif/fm_scan_control_status_test.sv
// Purpose: Self-checking bench of the scan control and status bank
// Assumes: Inputs change on the falling edge, read data one cycle late
// Notes: Scans are short ranges so each finishes in under a hundred cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %0t got %h expected %h", $time, got, exp); end end
module fm_scan_control_status_test;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [9:0] host_idx = 10'h018;
  fmscs_pkg::fmscs_scan_cfg_t cfg = '0;
  fmscs_pkg::fmscs_meas_t meas;
  logic pref = 1'b1;
  logic [9:0] idx_o;
  logic [16:0] freq_o;
  logic inj_o;
  logic img_o;
  logic [2:0] code_o;
  logic [9:0] sta_a = 10'h014;
  logic [9:0] sta_b = 10'h018;
  logic [7:0] signal_to_noise_level = 8'hA5;
  logic [2:0] flags = 3'b101;
  int bad_count = 0;
  int n_tests = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  fmscs_top u_fmscs_top (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .tuned_station_index_i(host_idx),
    .scan_cfg_i(cfg), .meas_i(meas), .image_pref_i(pref),
    .tuned_station_index_o(idx_o), .tuned_freq_khz_o(freq_o),
    .reference_injection_type_o(inj_o), .image_side_o(img_o), .fsm_code_o(code_o)
  );

  fmscs_rf_model u_fmscs_rf_model (
    .clk_sys_i(clk_sys_i), .index_i(idx_o), .station_a_i(sta_a),
    .station_b_i(sta_b), .snr_i(signal_to_noise_level), .flags_i(flags), .meas_o(meas)
  );

  // Single exit point for both the normal end and the watchdog
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // One-cycle write strobe, released before the next call can raise it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask : wr_reg

  // Address held one edge, data taken half a cycle after it lands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr = a;
    @(negedge clk_sys_i);
    d = rdata;
  endtask : rd_reg

  function automatic logic [16:0] freq_of(input logic [9:0] i);
    return 17'(fmscs_pkg::BASE_FREQ_KHZ + 17'(fmscs_pkg::STEP_KHZ) * 17'(i));
  endfunction : freq_of

  // Reset state, then calibration ends in idle
  task automatic t_reset;
    logic [7:0] d;
    @(negedge clk_sys_i);
    `CHK(code_o, fmscs_pkg::CODE_RESET)
    `CHK(rdata, 8'h00)
    sys_rst_i = 1'b0;
    repeat (fmscs_pkg::CAL_CYCLES + 6) @(negedge clk_sys_i);
    rd_reg(fmscs_pkg::ADDR_SYSTEM, d);
    `CHK(d, fmscs_pkg::SYSTEM_RESET)
    rd_reg(fmscs_pkg::ADDR_STATE, d);
    `CHK(d[6:4], fmscs_pkg::CODE_IDLE)
    `CHK(d[2:0], flags)
  endtask : t_reset

  // Injection type and image side follow host writes, read-only bytes hold
  task automatic t_config;
    logic [7:0] d;
    wr_reg(fmscs_pkg::ADDR_THRESHOLD, 8'h54);
    rd_reg(fmscs_pkg::ADDR_THRESHOLD, d);
    `CHK(d, 8'h54)
    `CHK(inj_o, 1'b0)
    `CHK(img_o, 1'b1)
    wr_reg(fmscs_pkg::ADDR_THRESHOLD, 8'h94);
    rd_reg(fmscs_pkg::ADDR_THRESHOLD, d);
    `CHK(d, 8'h94)
    `CHK(inj_o, 1'b1)
    `CHK(img_o, 1'b0)
    wr_reg(fmscs_pkg::ADDR_SNR, 8'hFF);
    rd_reg(fmscs_pkg::ADDR_SNR, d);
    `CHK(d, signal_to_noise_level)
    rd_reg(8'h07, d);
    `CHK(d, 8'h00)
  endtask : t_config

  // Starts a scan and polls the request bit until the device drops it
  task automatic run_scan(input logic [9:0] first, input logic [9:0] last,
                          input logic [1:0] step);
    logic [7:0] d;
    int n;
    bit seen_pll;
    bit seen_scan;
    seen_pll = 0;
    seen_scan = 0;
    n = 0;
    d = 8'h02;
    cfg = '{start_index: first, stop_index: last, fstep: step};
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h12);
    while (d[1] === 1'b1 && n < 2000)
    begin
      rd_reg(fmscs_pkg::ADDR_SYSTEM, d);
      if (code_o === fmscs_pkg::CODE_PLLCAL)
        seen_pll = 1;
      if (code_o === fmscs_pkg::CODE_RXSCAN)
        seen_scan = 1;
      n++;
    end
    `CHK(d, 8'h10)
    `CHK(seen_pll, 1'b1)
    `CHK(seen_scan, 1'b1)
    repeat (3) @(negedge clk_sys_i);
    `CHK(code_o, fmscs_pkg::CODE_RECEIVE)
  endtask : run_scan

  // Two stations in range: the weaker first one wins, not the strongest
  task automatic t_scan_hit;
    logic [7:0] d;
    run_scan(10'h00A, 10'h01E, 2'b01);
    `CHK(idx_o, sta_a)
    `CHK(freq_o, freq_of(sta_a))
    rd_reg(fmscs_pkg::ADDR_STATE, d);
    `CHK(d[3], 1'b0)
    rd_reg(fmscs_pkg::ADDR_THRESHOLD, d);
    `CHK(d[6], pref)
    `CHK(img_o, pref)
    // Single-index step must land on the station a coarser step skips
    run_scan(10'h013, 10'h01E, 2'b00);
    `CHK(idx_o, sta_a)
  endtask : t_scan_hit

  // Floor level equals threshold minus ten exactly, so every channel misses
  task automatic t_scan_miss;
    logic [7:0] d;
    logic [7:0] d2;
    run_scan(10'h028, 10'h02D, 2'b10);
    `CHK(idx_o, 10'h02D)
    `CHK(freq_o, freq_of(10'h02D))
    rd_reg(fmscs_pkg::ADDR_STATE, d);
    rd_reg(fmscs_pkg::ADDR_STATE, d2);
    `CHK(d[3], 1'b1)
    `CHK(d2, d)
  endtask : t_scan_miss

  // Scan bit alone never scans; host index is used once source is one
  task automatic t_manual;
    logic [7:0] d;
    bit seen_scan;
    seen_scan = 0;
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h02);
    repeat (40)
    begin
      @(negedge clk_sys_i);
      if (code_o === fmscs_pkg::CODE_RXSCAN)
        seen_scan = 1;
    end
    `CHK(seen_scan, 1'b0)
    flags = 3'b010;
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h11);
    repeat (fmscs_pkg::PLL_CYCLES + 8) @(negedge clk_sys_i);
    `CHK(idx_o, host_idx)
    `CHK(freq_o, freq_of(host_idx))
    rd_reg(fmscs_pkg::ADDR_RSSI, d);
    `CHK(d, 8'h2F)
    rd_reg(fmscs_pkg::ADDR_STATE, d);
    `CHK(d[6:4], fmscs_pkg::CODE_RECEIVE)
    `CHK(d[3:0], 4'hA)
  endtask : t_manual

  // Clearing receive mid-scan aborts it; soft reset restores defaults
  task automatic t_restart;
    logic [7:0] d;
    cfg = '{start_index: 10'h028, stop_index: 10'h02D, fstep: 2'b10};
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h12);
    repeat (fmscs_pkg::PLL_CYCLES + 6) @(negedge clk_sys_i);
    `CHK(code_o, fmscs_pkg::CODE_RXSCAN)
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h22);
    @(negedge clk_sys_i);
    `CHK(code_o, fmscs_pkg::CODE_STANDBY)
    rd_reg(fmscs_pkg::ADDR_SYSTEM, d);
    `CHK(d, 8'h20)
    wr_reg(fmscs_pkg::ADDR_SYSTEM, 8'h80);
    `CHK(code_o, fmscs_pkg::CODE_RESET)
    rd_reg(fmscs_pkg::ADDR_SYSTEM, d);
    `CHK(d, fmscs_pkg::SYSTEM_RESET)
    `CHK(code_o, fmscs_pkg::CODE_CAL)
    rd_reg(fmscs_pkg::ADDR_THRESHOLD, d);
    `CHK(d, fmscs_pkg::THRESHOLD_RESET)
    `CHK(inj_o, 1'b0)
    repeat (fmscs_pkg::CAL_CYCLES) @(negedge clk_sys_i);
    `CHK(code_o, fmscs_pkg::CODE_IDLE)
  endtask : t_restart

  // Main sequence: reset held for twelve cycles first
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    t_reset();
    t_config();
    t_scan_hit();
    t_scan_miss();
    t_manual();
    t_restart();
    wrap_up();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #(20000 * 50);
    bad_count++;
    wrap_up();
  end
endmodule : fm_scan_control_status_test
`default_nettype wire
